// File: logic/adsq_pkg.sv
// constants, register map and state codes of the sweep sequencer
package adsq_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] RES_BASE = 12'h020;
  localparam logic [11:0] RES_LAST = 12'h03C;
  // control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_GRP = 3;
  localparam int CTRL_DIV = 5;
  localparam int CTRL_EXT = 7;
  localparam int CTRL_SH = 8;
  localparam int CTRL_R8 = 9;
  localparam int CTRL_KEY = 10;
  // status field positions
  localparam int STAT_IRQ = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_KEY = 2;
  localparam int STAT_CH = 4;
  // sweep modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_REP0 = 2'h1;
  localparam logic [1:0] MODE_REP1 = 2'h2;
  // divider code 0 is /4, 3 is undivided
  localparam logic [1:0] DIV_TOP = 2'h3;
  // sample phase length in operation-clock ticks
  localparam logic [1:0] SAMP_TICKS = 2'h3;
  // successive approximation start value and top bit
  localparam logic [9:0] SAR_INIT = 10'h200;
  localparam logic [3:0] SAR_MSB = 4'h9;
  // register selector codes
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_STAT = 2'h1;
  localparam logic [1:0] SEL_RES = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMP = 2'b01,
    ST_CONV = 2'b10
  } adsq_state_e;
endpackage

// File: logic/adsq_sweep_seq.sv
// sweep sequencer for an eight-channel successive-approximation converter
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
//
// Contract
// - a started sweep always converts channel zero first
// - the channel zero result lands in result register zero
// - single sweep converts each selected channel and stores it per channel
// - single sweep end sets the done bit, clears start, halts
// - single and repeat 0 groups are two, four, six or eight channels
// - repeat 0 cycles the group, stores each result, never sets done
// - repeat 0 runs until software writes start to zero
// - repeat 1 groups are one, two, three or four channels
// - repeat 1 adds one channel outside the group, then restarts at zero
// - repeat 1 stores per channel, never sets done, runs until start clears
// - operation clock is base clock divided by four, three, two or one
// - sweeps start from the software flag or the trigger pin
// - done bit marks completion; software checks it before reading
// - with key interrupt enabled, a low channel raises it and blocks use
// - with trigger source chosen and start set, a falling edge starts
// - with sample and hold, sample three ticks before comparing
// - eight-bit resolution keeps the top eight result bits
module adsq_sweep_seq
  import adsq_pkg::*;
#(
  parameter int AW = 12
)
(
  input wire logic pclk, // bus and converter base clock
  input wire logic presetn, // asynchronous reset
  input wire logic ce, // clock enable, freezes all state
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic cmp_in, // comparator: input above trial level
  input wire logic external_conversion_trigger, // trigger pin
  input wire logic [7:0] analog_channel_n, // digital level of the analog pins
  output logic [2:0] mux_sel, // analog multiplexer select
  output logic [9:0] trial_code, // trial code for the reference ladder
  output logic sample_on, // sample switch closed
  output logic key_irq // key input interrupt request
);

  typedef struct packed {
    adsq_state_e st;
    logic samp;
    logic [1:0] div_cnt;
    logic [1:0] samp_cnt;
    logic [3:0] bitn;
    logic [9:0] sar;
    logic [2:0] ch;
    logic [2:0] oc;
    logic outer;
    logic start;
    logic irq;
    logic [1:0] mode;
    logic [1:0] grp;
    logic [1:0] div;
    logic ext;
    logic sh;
    logic r8;
    logic key_en;
    logic [7:0][9:0] res;
    logic [2:0] trg_s;
    logic trg_low;
    logic [7:0] lv_s1;
    logic [7:0] lv_s2;
    logic [7:0] lv_s3;
    logic [7:0] lv_low;
    logic key_irq;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } adsq_s;

  adsq_s s_reg;
  adsq_s s_next;
  logic tick;
  logic fall;
  logic last;
  logic go;
  logic store;
  logic launch;
  logic ch_may;
  logic acc;
  logic irq_set;
  logic start_clr;
  logic [7:0] lv_agree;
  logic [9:0] sar_fin;
  logic [9:0] wr_val;
  logic [1:0] sel;

  // decode an address into a register selector
  function automatic logic [1:0] reg_sel(input logic [AW-1:0] a);
    logic [11:0] w;
    w = 12'(a);
    if (a[1:0] != 2'h0 || AW > 12 && (a >> 12) != '0)
      return SEL_NONE;
    if (w == CTRL_OFS)
      return SEL_CTRL;
    if (w == STAT_OFS)
      return SEL_STAT;
    if (w >= RES_BASE && w <= RES_LAST)
      return SEL_RES;
    return SEL_NONE;
  endfunction

  // helper terms of the current state
  always_comb
  begin
    tick = s_reg.div_cnt >= (DIV_TOP - s_reg.div);
    fall = !s_reg.trg_low && s_reg.trg_s[2:1] == 2'b11;
    if (s_reg.mode == MODE_REP1)
      last = s_reg.ch == {1'b0, s_reg.grp};
    else
      last = s_reg.ch == {s_reg.grp, 1'b1};
    sar_fin = {s_reg.sar[9:1], cmp_in};
    wr_val = s_reg.r8 ? {2'b00, sar_fin[9:2]} : sar_fin;
    lv_agree = ~(s_reg.lv_s2 ^ s_reg.lv_s3);
    acc = psel && penable && s_reg.pready;
    sel = reg_sel(paddr);
    ch_may = s_reg.st == ST_IDLE || s_reg.bitn == 4'h0;
  end

  // next state of the whole block
  always_comb
  begin
    s_next = s_reg;
    go = 1'b0;
    store = 1'b0;
    launch = 1'b0;
    irq_set = 1'b0;
    start_clr = 1'b0;
    if (ce)
    begin
      // inverted pin synchronisers, reset reads as idle high; stages two and three must agree
      s_next.trg_s = {s_reg.trg_s[1:0], ~external_conversion_trigger};
      if (s_reg.trg_s[1] == s_reg.trg_s[2])
        s_next.trg_low = s_reg.trg_s[2];
      s_next.lv_s1 = ~analog_channel_n;
      s_next.lv_s2 = s_reg.lv_s1;
      s_next.lv_s3 = s_reg.lv_s2;
      s_next.lv_low = (s_reg.lv_low & ~lv_agree) | (s_reg.lv_s3 & lv_agree);
      s_next.key_irq = s_reg.key_en && |s_reg.lv_low;
      // operation clock divider
      s_next.div_cnt = tick ? 2'h0 : s_reg.div_cnt + 2'h1;
      // conversion sequencer
      unique case (s_reg.st)
        ST_IDLE:
        begin
          // key input use blocks conversion on the shared pins
          go = s_reg.start && !s_reg.key_en && (!s_reg.ext || fall);
          if (go)
          begin
            s_next.ch = 3'h0;
            s_next.outer = 1'b0;
            s_next.oc = {1'b0, s_reg.grp} + 3'h1;
            launch = 1'b1;
          end
        end
        ST_SAMP:
        begin
          if (tick)
          begin
            if (s_reg.samp_cnt == SAMP_TICKS - 2'h1)
            begin
              s_next.st = ST_CONV;
              s_next.sar = SAR_INIT;
              s_next.bitn = SAR_MSB;
            end
            else
              s_next.samp_cnt = s_reg.samp_cnt + 2'h1;
          end
        end
        ST_CONV:
        begin
          if (tick)
          begin
            s_next.sar[s_reg.bitn] = cmp_in;
            if (s_reg.bitn == 4'h0)
              store = 1'b1;
            else
            begin
              s_next.sar[s_reg.bitn - 4'h1] = 1'b1;
              s_next.bitn = s_reg.bitn - 4'h1;
            end
          end
        end
        default:
          s_next.st = ST_IDLE;
      endcase
      // store the result and pick the next channel
      if (store)
      begin
        s_next.res[s_reg.ch] = wr_val;
        launch = 1'b1;
        if (s_reg.mode == MODE_REP1)
        begin
          if (s_reg.outer)
          begin
            s_next.ch = 3'h0;
            s_next.outer = 1'b0;
            if (s_reg.oc == 3'h7)
              s_next.oc = {1'b0, s_reg.grp} + 3'h1;
            else
              s_next.oc = s_reg.oc + 3'h1;
          end
          else if (last)
          begin
            s_next.ch = s_reg.oc;
            s_next.outer = 1'b1;
          end
          else
            s_next.ch = s_reg.ch + 3'h1;
        end
        else if (last)
        begin
          s_next.ch = 3'h0;
          if (s_reg.mode != MODE_REP0 && s_reg.mode != MODE_REP1)
          begin
            irq_set = 1'b1;
            start_clr = 1'b1;
            launch = 1'b0;
            s_next.st = ST_IDLE;
          end
        end
        else
          s_next.ch = s_reg.ch + 3'h1;
      end
      // begin a channel with sampling or straight comparison
      if (launch)
      begin
        s_next.st = s_reg.sh ? ST_SAMP : ST_CONV;
        s_next.samp_cnt = 2'h0;
        s_next.sar = SAR_INIT;
        s_next.bitn = SAR_MSB;
      end
      // a cleared start flag stops any running sweep
      if (s_reg.st != ST_IDLE && !s_reg.start)
        s_next.st = ST_IDLE;
      s_next.samp = s_next.st == ST_SAMP; // sample switch level, registered
      // apb answer one cycle into the access phase
      s_next.pready = psel && penable && !s_reg.pready;
      s_next.pslverr = 1'b0;
      if (psel && penable && !s_reg.pready)
      begin
        s_next.pslverr = sel == SEL_NONE;
        unique case (sel)
          SEL_CTRL:
            s_next.prdata = {21'h0, s_reg.key_en, s_reg.r8, s_reg.sh, s_reg.ext,
              s_reg.div, s_reg.grp, s_reg.mode, s_reg.start};
          SEL_STAT:
            s_next.prdata = {25'h0, s_reg.ch, 1'b0, s_reg.key_irq,
              s_reg.st != ST_IDLE, s_reg.irq};
          SEL_RES:
            s_next.prdata = {22'h0, s_reg.res[paddr[4:2]]};
          SEL_NONE:
            s_next.prdata = 32'h0;
        endcase
      end
      // software writes; a hardware set of done beats a clear
      s_next.start = s_reg.start && !start_clr;
      s_next.irq = s_reg.irq;
      if (acc && pwrite && sel == SEL_CTRL)
      begin
        s_next.start = pwdata[CTRL_START];
        s_next.mode = pwdata[CTRL_MODE +: 2];
        s_next.grp = pwdata[CTRL_GRP +: 2];
        s_next.div = pwdata[CTRL_DIV +: 2];
        s_next.ext = pwdata[CTRL_EXT];
        s_next.sh = pwdata[CTRL_SH];
        s_next.r8 = pwdata[CTRL_R8];
        s_next.key_en = pwdata[CTRL_KEY];
      end
      if (acc && pwrite && sel == SEL_STAT && pwdata[STAT_IRQ])
        s_next.irq = 1'b0;
      if (irq_set)
        s_next.irq = 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign mux_sel = s_reg.ch;
  assign trial_code = s_reg.sar;
  assign sample_on = s_reg.samp;
  assign key_irq = s_reg.key_irq;

  // checks on the sequencer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  start_first_a: assert property (
    ce && go |=> s_reg.ch == 3'h0 && s_reg.st != ST_IDLE)
    else $error("sweep did not start at channel zero");

  store_slot_a: assert property (
    ce && store |=> s_reg.res[$past(s_reg.ch)] == $past(wr_val))
    else $error("result not stored in its channel register");

  index_hold_a: assert property (
    ce && !ch_may |=> $stable(s_reg.ch))
    else $error("channel index moved without a store");

  single_end_a: assert property (
    ce && store && last && s_reg.mode == MODE_SINGLE
      |=> s_reg.irq && s_reg.st == ST_IDLE ##1 s_reg.st == ST_IDLE || s_reg.start)
    else $error("single sweep did not finish properly");

  repeat_noirq_a: assert property (
    ce && store && !s_reg.irq && (s_reg.mode == MODE_REP0 || s_reg.mode == MODE_REP1)
      |=> !s_reg.irq)
    else $error("repeat sweep raised the done bit");

  repeat_wrap_a: assert property (
    ce && store && last && s_reg.start && s_reg.mode == MODE_REP0
      |=> s_reg.ch == 3'h0 && s_reg.st != ST_IDLE)
    else $error("repeat sweep 0 did not wrap");

  outer_pick_a: assert property (
    ce && store && last && !s_reg.outer && s_reg.mode == MODE_REP1
      |=> s_reg.ch == $past(s_reg.oc) && s_reg.ch > {1'b0, s_reg.grp})
    else $error("outside channel not taken after group");

  outer_rotate_a: assert property (
    ce && store && s_reg.outer && s_reg.mode == MODE_REP1
      |=> s_reg.ch == 3'h0 && s_reg.oc != $past(s_reg.oc))
    else $error("outside channel did not rotate");

  stop_flag_a: assert property (
    ce && s_reg.st != ST_IDLE && !s_reg.start |=> s_reg.st == ST_IDLE)
    else $error("sweep kept running with start cleared");

  sample_len_a: assert property (
    ce && s_reg.start && s_reg.st == ST_SAMP && tick && s_reg.samp_cnt == 2'h2
      |=> s_reg.st == ST_CONV)
    else $error("sample phase length wrong");

  freeze_a: assert property (
    !ce |=> $stable(s_reg))
    else $error("state moved with clock enable low");

endmodule

// File: verification/adsq_ana_model.sv
// analog multiplexer and comparator model at the far side of the sequencer
`timescale 1ns/1ns
module adsq_ana_model
(
  input wire logic pclk, // base clock
  input wire logic [79:0] vin_flat, // level of each channel in code steps
  input wire logic [2:0] mux_sel, // channel select
  input wire logic [9:0] trial_code, // ladder trial code
  input wire logic sample_on, // sample switch closed
  output logic cmp_in // input above trial level
);
  logic noise_reg = 1'b0;
  // comparator output is meaningless while the switch samples
  always @(posedge pclk)
    noise_reg <= ~noise_reg;
  // ladder level n sits half a step below code n, so the flag is level >= trial
  assign cmp_in = sample_on ? noise_reg : (vin_flat[int'(mux_sel)*10 +: 10] >= trial_code);
endmodule

// File: verification/tb_adsq_sweep_seq.sv
// testbench of the sweep sequencer: register bus, sweeps, trigger and key input
`timescale 1ns/1ns
module tb_adsq_sweep_seq import adsq_pkg::*;;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ce = 1'b1;
  logic trig = 1'b1;
  logic [7:0] pins_n = 8'hFF;
  logic [79:0] vin_flat = 80'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmp_in, sample_on, key_irq;
  logic [2:0] mux_sel;
  logic [9:0] trial_code;
  int errors = 0;
  int checks_done = 0;
  int samp_cnt = 0;
  logic [2:0] seen[$];
  logic [2:0] last_mux = 3'h0;
  // design and its analog partner
  adsq_sweep_seq dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .external_conversion_trigger(trig),
    .analog_channel_n(pins_n), .mux_sel(mux_sel), .trial_code(trial_code),
    .sample_on(sample_on), .key_irq(key_irq));
  adsq_ana_model ana_u (.pclk(pclk), .vin_flat(vin_flat), .mux_sel(mux_sel),
    .trial_code(trial_code), .sample_on(sample_on), .cmp_in(cmp_in));
  // clock
  initial
    forever #2 pclk = ~pclk;
  // counts sampling cycles and records each channel change
  always @(posedge pclk)
  begin
    if (sample_on === 1'b1)
      samp_cnt++;
    if (mux_sel !== last_mux)
      seen.push_back(mux_sel);
    last_mux <= mux_sel;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // one bus transfer; data and error are taken at the rising edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40)
      chk(0, 1, "bus hang");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
    input string s);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x, s);
  endtask
  // control word, o holds key, 8-bit, sample and hold, trigger source
  function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] g,
    input logic [1:0] dv, input logic [3:0] o);
    return {21'h0, o, dv, g, md, 1'b0};
  endfunction
  function automatic logic [9:0] vv(input int c, input int g);
    return 10'((c * 97 + g * 211 + 5) % 1024);
  endfunction
  task automatic setv(input int g);
    @(posedge pclk);
    for (int c = 0; c < 8; c++)
      vin_flat[c*10 +: 10] <= vv(c, g);
  endtask
  // configure while stopped, then set start
  task automatic go(input logic [31:0] c);
    wr(STAT_OFS, 32'h1);
    wr(CTRL_OFS, c);
    repeat (4) @(posedge pclk);
    samp_cnt = 0;
    wr(CTRL_OFS, c | 32'h1);
  endtask
  task automatic wait_done();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, STAT_OFS, 32'h0, r, e);
      n++;
    end
    while (r[STAT_IRQ] !== 1'b1 && n < 300);
    chk(32'(r[STAT_IRQ]), 1, "sweep never done");
  endtask
  task automatic t_bus();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk(32'(e), 1, "no error on unmapped read");
    chk(r, 0, "unmapped read data");
    wr(RES_BASE, 32'h155);
    rd(RES_BASE, ALL, 32'h0, "result register writable");
    $display("test bus done");
  endtask
  // every group size and divider code, with sample and hold
  task automatic t_single();
    int e;
    for (int g = 0; g < 4; g++)
    begin
      setv(g);
      go(ctl(MODE_SINGLE, 2'(g), 2'(g), 4'h2));
      @(posedge pclk);
      @(negedge pclk);
      chk(32'(mux_sel), 0, "sweep not at channel 0");
      wait_done();
      e = 3 * (2 * g + 2) * (4 - g);
      chk(32'(samp_cnt >= e - 4 + g && samp_cnt <= e + 4 - g), 1, "sample time");
      rd(CTRL_OFS, 32'h1, 32'h0, "start not cleared");
      rd(STAT_OFS, 32'h2, 32'h0, "still busy");
      for (int c = 0; c < 2 * g + 2; c++)
        rd(RES_BASE + 12'(4 * c), ALL, 32'(vv(c, g)), "wrong result");
      if (g < 3)
        rd(RES_BASE + 12'(8 * g + 8), ALL, 32'h0, "outside group written");
    end
    $display("test single sweep done");
  endtask
  task automatic t_rep(input logic [1:0] md, input int g, input int n);
    logic [2:0] exp[$];
    int k;
    for (int p = 0; p < n; p++)
      if (md == MODE_REP0)
        for (int c = 0; c < 2 * g + 2; c++)
          exp.push_back(3'(c));
      else
      begin
        for (int c = 0; c <= g; c++)
          exp.push_back(3'(c));
        exp.push_back(3'(g + 1 + p % (7 - g)));
      end
    void'(exp.pop_front());
    setv(5);
    go(ctl(md, 2'(g), DIV_TOP, 4'h0));
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(mux_sel), 0, "sweep not at channel 0");
    @(negedge pclk);
    seen.delete();
    k = 0;
    while (seen.size() < exp.size() && k < 5000)
    begin
      @(posedge pclk);
      k++;
    end
    foreach (exp[i])
      chk(32'(seen[i]), 32'(exp[i]), "wrong channel order");
    rd(RES_BASE + 12'h00C, ALL, 32'(vv(3, 5)), "repeat result");
    wr(CTRL_OFS, 32'h0);
    repeat (20) @(posedge pclk);
    rd(STAT_OFS, 32'h3, 32'h0, "done set or still busy");
    k = seen.size();
    repeat (40) @(posedge pclk);
    chk(32'(seen.size()), 32'(k), "runs after stop");
    $display("test repeat sweep done");
  endtask
  // clock enable low in mid-conversion freezes the sweep, which then resumes
  task automatic t_freeze();
    logic [9:0] tc;
    logic [2:0] ms;
    int k;
    setv(2);
    go(ctl(MODE_REP0, 2'h3, DIV_TOP, 4'h0));
    repeat (37) @(posedge pclk);
    ce <= 1'b0;
    @(negedge pclk);
    tc = trial_code;
    ms = mux_sel;
    k = seen.size();
    repeat (30) @(posedge pclk);
    @(negedge pclk);
    chk(32'(trial_code), 32'(tc), "trial code moved while frozen");
    chk(32'(mux_sel), 32'(ms), "channel moved while frozen");
    chk(32'(seen.size()), 32'(k), "sweep ran while frozen");
    @(posedge pclk);
    ce <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(seen.size() > k), 1, "sweep did not resume");
    wr(CTRL_OFS, 32'h0);
    $display("test clock enable done");
  endtask
  task automatic t_ext();
    setv(6);
    go(ctl(MODE_SINGLE, 2'h0, DIV_TOP, 4'h5));
    repeat (30) @(posedge pclk);
    rd(STAT_OFS, 32'h3, 32'h0, "started without edge");
    trig <= 1'b0;
    wait_done();
    rd(RES_BASE, ALL, 32'(vv(0, 6) >> 2), "8-bit result");
    rd(RES_BASE + 12'h004, ALL, 32'(vv(1, 6) >> 2), "8-bit result");
    trig <= 1'b1;
    $display("test trigger done");
  endtask
  task automatic t_key();
    wr(CTRL_OFS, ctl(MODE_SINGLE, 2'h0, DIV_TOP, 4'h8));
    repeat (8) @(negedge pclk);
    chk(32'(key_irq), 0, "key irq with pins high");
    @(posedge pclk);
    pins_n <= 8'hF7;
    repeat (8) @(negedge pclk);
    chk(32'(key_irq), 1, "no key irq");
    rd(STAT_OFS, 32'h4, 32'h4, "key status clear");
    wr(CTRL_OFS, ctl(MODE_SINGLE, 2'h0, DIV_TOP, 4'h8) | 32'h1);
    repeat (20) @(posedge pclk);
    rd(STAT_OFS, 32'h2, 32'h0, "converts with key input on");
    pins_n <= 8'hFF;
    wr(CTRL_OFS, 32'h0);
    $display("test key input done");
  endtask
  // reset, then the tests in turn
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_single();
    t_rep(MODE_REP0, 1, 3);
    t_rep(MODE_REP1, 0, 8);
    t_rep(MODE_REP1, 3, 5);
    t_freeze();
    t_ext();
    t_key();
    finish_test();
  end
  // watchdog
  initial
  begin
    repeat (40000) @(posedge pclk);
    errors++;
    $display("Error at %0t: watchdog", $time);
    finish_test();
  end
endmodule
